//--- inc/tm_pkg.sv
// Functional notes
// - busy bit 7 reads 1 during a conversion, never drives either pin
// - status bit 6 sets when inner reading exceeds upper bound, asserts alert
// - status bit 5 sets in interrupt mode when inner reading at or below lower bound, asserts alert
// - status bit 4 sets when outer reading exceeds upper bound, asserts alert
// - status bit 3 sets in interrupt mode when outer reading at or below lower bound, asserts alert
// - status bit 2 sets on outer diode fault in interrupt mode, asserts alert
// - status bit 1 sets on outer critical, drives critical pin, clears on release
// - status bit 0 sets on inner critical, drives critical pin, clears on release
// - status bits 6..2 stay set until read, unless alert acts as critical output
// - pins assert only after programmed consecutive out-of-limit count is reached
// - setup bit 7 masks alert pin, flags still update, not in critical mode
// - setup bit 6 zero converts continuously, one selects standby, converting only on one-shot
// - setup bit 5 selects comparator alert and ignores mask; zero gives interrupt
// - setup bit 4 set disables series resistance correction on outer channel
// - setup bit 2 selects plain binary range or offset binary extended range
// - setup bit 1 disables adaptive averaging, limiting averaging to 1x
// - pace code doubles rate per step, 1/16 s at 0h to 64/s at Ah, reset 06h
// - pace register answers at 04h and 0Ah and paces measure and compare
// - low event at reading less or equal, high event only strictly above
// - mirrored limit registers behave identically at both addresses, 05h-08h and 0Bh-0Eh
// - in standby new limits act only at next conversion, one-shot or run
// - one-shot write in standby while idle starts one conversion; active ignores it
// - critical pin releases below limit minus hysteresis and cannot be masked
package tm_pkg;
    localparam logic [7:0] TM_ADDR_FLAGS = 8'h02;
    localparam logic [7:0] TM_ADDR_SETUP = 8'h03;
    localparam logic [7:0] TM_ADDR_PACE = 8'h04;
    localparam logic [7:0] TM_ADDR_IUB = 8'h05;
    localparam logic [7:0] TM_ADDR_ILB = 8'h06;
    localparam logic [7:0] TM_ADDR_OUB = 8'h07;
    localparam logic [7:0] TM_ADDR_OLB = 8'h08;
    localparam logic [7:0] TM_ADDR_SETUP_ALIAS = 8'h09;
    localparam logic [7:0] TM_ADDR_PACE_ALIAS = 8'h0a;
    localparam logic [7:0] TM_ADDR_IUB_ALIAS = 8'h0b;
    localparam logic [7:0] TM_ADDR_ILB_ALIAS = 8'h0c;
    localparam logic [7:0] TM_ADDR_OUB_ALIAS = 8'h0d;
    localparam logic [7:0] TM_ADDR_OLB_ALIAS = 8'h0e;
    localparam logic [7:0] TM_ADDR_ONE_SHOT = 8'h0f;
    localparam logic [7:0] TM_ADDR_OUB_FRAC = 8'h13;
    localparam logic [7:0] TM_ADDR_OLB_FRAC = 8'h14;

    localparam int TM_FLAG_BUSY = 7;
    localparam int TM_FLAG_IHI = 6;
    localparam int TM_FLAG_ILO = 5;
    localparam int TM_FLAG_EHI = 4;
    localparam int TM_FLAG_ELO = 3;
    localparam int TM_FLAG_FAULT = 2;
    localparam int TM_FLAG_ECRIT = 1;
    localparam int TM_FLAG_ICRIT = 0;

    localparam int TM_SETUP_MASK_ALL = 7;
    localparam int TM_SETUP_STANDBY = 6;
    localparam int TM_SETUP_COMP = 5;
    localparam int TM_SETUP_FIX_OFF = 4;
    localparam int TM_SETUP_RANGE = 2;
    localparam int TM_SETUP_AVG_OFF = 1;
    localparam logic [7:0] TM_SETUP_WMASK = 8'hf6;
    localparam logic [7:0] TM_FRAC_WMASK = 8'he0;

    localparam logic [7:0] TM_RST_SETUP = 8'h00;
    localparam logic [3:0] TM_RST_PACE = 4'h6;
    localparam logic [7:0] TM_RST_UB = 8'h55;
    localparam logic [7:0] TM_RST_LB = 8'h00;
    localparam logic [2:0] TM_RST_FRAC = 3'h0;
    localparam logic [3:0] TM_PACE_MAX = 4'ha;

    // conversion period at the fastest code; slower codes double it per step
    localparam int TM_CLK_NS = 8;
    localparam int TM_FAST_PERIOD_NS = 15625000;
    localparam logic [31:0] TM_FAST_CYC = 32'(TM_FAST_PERIOD_NS / TM_CLK_NS);

    typedef struct packed {
        logic valid;
        logic [7:0] inner_temp;
        logic [7:0] outer_int;
        logic [2:0] outer_frac;
        logic outer_fault;
    } tm_sample_t;

    typedef struct packed {
        logic [7:0] inner_crit_limit;
        logic [7:0] outer_crit_limit;
        logic [7:0] crit_hyst;
        logic [2:0] alert_count;
        logic [2:0] crit_count;
    } tm_thresh_t;

    typedef struct packed {
        logic [7:0] setup;
        logic [3:0] pace;
        logic [7:0] iub;
        logic [7:0] ilb;
        logic [7:0] oub;
        logic [7:0] olb;
        logic [2:0] oub_frac;
        logic [2:0] olb_frac;
        logic [6:0] flags;
        logic busy;
        logic [31:0] timer;
        logic conv_start;
        logic [2:0] i_acnt;
        logic [2:0] e_acnt;
        logic [2:0] i_ccnt;
        logic [2:0] e_ccnt;
        logic i_cmp;
        logic e_cmp;
        logic i_crit;
        logic e_crit;
        logic [7:0] rdata;
        logic rvalid;
    } tm_state_t;
endpackage

//--- design/tm_monitor.sv
`timescale 1ns/100ps
module tm_monitor
    import tm_pkg::*;
#(
    parameter logic [31:0] FAST_CYC = TM_FAST_CYC
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire tm_sample_t sample,
    input wire tm_thresh_t thresh,
    input wire logic alert_as_crit,
    output logic conv_start,
    output logic range_ext,
    output logic series_resistance_fix,
    output logic adaptive_averaging_off,
    output logic [3:0] sample_pace_code,
    output logic alert_pin_o,
    output logic alert_pin_oe,
    output logic crit_pin_o,
    output logic crit_pin_oe
);
    tm_state_t state_reg;
    tm_state_t state_next;

    logic [3:0] pace_eff;
    logic [3:0] pace_shift;
    logic [31:0] period;
    logic wr_any;
    logic rd_flags;
    logic start_req;
    logic [10:0] outer_t;
    logic [10:0] oub_full;
    logic [10:0] olb_full;
    logic ihi;
    logic ilo;
    logic ehi;
    logic elo;
    logic i_err;
    logic e_err;
    logic i_over;
    logic e_over;
    logic [2:0] i_n;
    logic [2:0] e_n;
    logic [4:0] cond_now;
    logic [6:2] set_bits;
    logic [6:2] clr_bits;
    logic [7:0] rd_mux;

    // codes above Ah run at the fastest rate
    assign pace_eff = (state_reg.pace > TM_PACE_MAX) ? TM_PACE_MAX : state_reg.pace;
    assign pace_shift = TM_PACE_MAX - pace_eff;
    assign period = FAST_CYC << pace_shift;

    // integer byte joined with three fraction bits
    assign outer_t = {sample.outer_int, sample.outer_frac};
    assign oub_full = {state_reg.oub, state_reg.oub_frac};
    assign olb_full = {state_reg.olb, state_reg.olb_frac};

    assign ihi = sample.inner_temp > state_reg.iub;
    assign ilo = sample.inner_temp <= state_reg.ilb;
    assign ehi = outer_t > oub_full;
    assign elo = outer_t <= olb_full;
    assign i_err = ihi | ilo;
    assign e_err = ehi | elo | sample.outer_fault;
    assign i_over = sample.inner_temp > thresh.inner_crit_limit;
    assign e_over = sample.outer_int > thresh.outer_crit_limit;
    assign i_n = state_reg.i_acnt + 3'h1;
    assign e_n = state_reg.e_acnt + 3'h1;
    assign cond_now = {ihi, ilo, ehi, elo, sample.outer_fault};

    always_comb
    begin
        case (reg_addr)
            // busy in bit 7 over the sticky flags
            TM_ADDR_FLAGS: rd_mux = {state_reg.busy, state_reg.flags};
            TM_ADDR_SETUP, TM_ADDR_SETUP_ALIAS: rd_mux = state_reg.setup;
            TM_ADDR_PACE, TM_ADDR_PACE_ALIAS: rd_mux = {4'h0, state_reg.pace};
            TM_ADDR_IUB, TM_ADDR_IUB_ALIAS: rd_mux = state_reg.iub;
            TM_ADDR_ILB, TM_ADDR_ILB_ALIAS: rd_mux = state_reg.ilb;
            TM_ADDR_OUB, TM_ADDR_OUB_ALIAS: rd_mux = state_reg.oub;
            TM_ADDR_OLB, TM_ADDR_OLB_ALIAS: rd_mux = state_reg.olb;
            TM_ADDR_OUB_FRAC: rd_mux = {state_reg.oub_frac, 5'h00};
            TM_ADDR_OLB_FRAC: rd_mux = {state_reg.olb_frac, 5'h00};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.conv_start = 1'b0;
        state_next.rvalid = reg_rd_en;
        set_bits = 5'h00;
        clr_bits = 5'h00;
        wr_any = reg_wr_en;
        rd_flags = reg_rd_en && (reg_addr == TM_ADDR_FLAGS);
        start_req = 1'b0;

        if (reg_rd_en)
        begin
            state_next.rdata = rd_mux;
        end

        // reading clears the sticky flags unless alert is a critical output
        if (rd_flags && !alert_as_crit)
        begin
            clr_bits = 5'h1f;
        end

        if (wr_any)
        begin
            case (reg_addr)
                TM_ADDR_SETUP, TM_ADDR_SETUP_ALIAS:
                begin
                    state_next.setup = reg_wdata & TM_SETUP_WMASK;
                    // leaving standby starts a conversion at once
                    if (state_reg.setup[TM_SETUP_STANDBY] && !reg_wdata[TM_SETUP_STANDBY]
                        && !state_reg.busy)
                    begin
                        start_req = 1'b1;
                    end
                end
                TM_ADDR_PACE, TM_ADDR_PACE_ALIAS: state_next.pace = reg_wdata[3:0];
                TM_ADDR_IUB, TM_ADDR_IUB_ALIAS: state_next.iub = reg_wdata;
                TM_ADDR_ILB, TM_ADDR_ILB_ALIAS: state_next.ilb = reg_wdata;
                TM_ADDR_OUB, TM_ADDR_OUB_ALIAS: state_next.oub = reg_wdata;
                TM_ADDR_OLB, TM_ADDR_OLB_ALIAS: state_next.olb = reg_wdata;
                TM_ADDR_OUB_FRAC: state_next.oub_frac = reg_wdata[7:5];
                TM_ADDR_OLB_FRAC: state_next.olb_frac = reg_wdata[7:5];
                TM_ADDR_ONE_SHOT:
                begin
                    // one-shot only in standby with no conversion running
                    if (state_reg.setup[TM_SETUP_STANDBY] && !state_reg.busy)
                    begin
                        start_req = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // pace timer runs only in active mode
        if (state_reg.setup[TM_SETUP_STANDBY])
        begin
            state_next.timer = 32'h0;
        end
        else if (state_reg.timer >= period - 32'h1)
        begin
            state_next.timer = 32'h0;
            // a conversion still running swallows this tick
            if (!state_reg.busy)
            begin
                start_req = 1'b1;
            end
        end
        else
        begin
            state_next.timer = state_reg.timer + 32'h1;
        end

        if (start_req)
        begin
            state_next.conv_start = 1'b1;
            state_next.busy = 1'b1;
        end

        // limits are only consulted when a result arrives
        if (sample.valid)
        begin
            state_next.busy = 1'b0;
            if (state_reg.setup[TM_SETUP_COMP])
            begin
                // comparator mode counts only high excursions and holds
                if (ihi)
                begin
                    if (i_n >= thresh.alert_count)
                    begin
                        state_next.i_cmp = 1'b1;
                        set_bits[TM_FLAG_IHI] = 1'b1;
                    end
                    else
                    begin
                        state_next.i_acnt = i_n;
                    end
                end
                else if (!state_reg.i_cmp ||
                         ({1'b0, sample.inner_temp} + {1'b0, thresh.crit_hyst}
                          < {1'b0, state_reg.iub}))
                begin
                    state_next.i_cmp = 1'b0;
                    state_next.i_acnt = 3'h0;
                end
                if (ehi)
                begin
                    if (e_n >= thresh.alert_count)
                    begin
                        state_next.e_cmp = 1'b1;
                        set_bits[TM_FLAG_EHI] = 1'b1;
                    end
                    else
                    begin
                        state_next.e_acnt = e_n;
                    end
                end
                else if (!state_reg.e_cmp ||
                         ({1'b0, outer_t} + {1'b0, thresh.crit_hyst, 3'h0}
                          < {1'b0, oub_full}))
                begin
                    state_next.e_cmp = 1'b0;
                    state_next.e_acnt = 3'h0;
                end
            end
            else
            begin
                state_next.i_cmp = 1'b0;
                state_next.e_cmp = 1'b0;
                // flags latch only when the consecutive count is reached
                if (i_err)
                begin
                    if (i_n >= thresh.alert_count)
                    begin
                        set_bits[TM_FLAG_IHI] = ihi;
                        // inner at or under lower bound
                        set_bits[TM_FLAG_ILO] = ilo;
                        state_next.i_acnt = 3'h0;
                    end
                    else
                    begin
                        state_next.i_acnt = i_n;
                    end
                end
                else
                begin
                    state_next.i_acnt = 3'h0;
                end
                if (e_err)
                begin
                    if (e_n >= thresh.alert_count)
                    begin
                        set_bits[TM_FLAG_EHI] = ehi;
                        // outer at or under lower bound
                        set_bits[TM_FLAG_ELO] = elo;
                        set_bits[TM_FLAG_FAULT] = sample.outer_fault;
                        state_next.e_acnt = 3'h0;
                    end
                    else
                    begin
                        state_next.e_acnt = e_n;
                    end
                end
                else
                begin
                    state_next.e_acnt = 3'h0;
                end
            end

            // inner critical releases below limit minus hysteresis
            if (state_reg.i_crit)
            begin
                if ({1'b0, sample.inner_temp} + {1'b0, thresh.crit_hyst}
                    < {1'b0, thresh.inner_crit_limit})
                begin
                    state_next.i_crit = 1'b0;
                    state_next.i_ccnt = 3'h0;
                end
            end
            else if (i_over)
            begin
                if (state_reg.i_ccnt + 3'h1 >= thresh.crit_count)
                begin
                    state_next.i_crit = 1'b1;
                    state_next.i_ccnt = 3'h0;
                end
                else
                begin
                    state_next.i_ccnt = state_reg.i_ccnt + 3'h1;
                end
            end
            else
            begin
                state_next.i_ccnt = 3'h0;
            end

            // outer critical releases below limit minus hysteresis
            if (state_reg.e_crit)
            begin
                if ({1'b0, sample.outer_int} + {1'b0, thresh.crit_hyst}
                    < {1'b0, thresh.outer_crit_limit})
                begin
                    state_next.e_crit = 1'b0;
                    state_next.e_ccnt = 3'h0;
                end
            end
            else if (e_over)
            begin
                if (state_reg.e_ccnt + 3'h1 >= thresh.crit_count)
                begin
                    state_next.e_crit = 1'b1;
                    state_next.e_ccnt = 3'h0;
                end
                else
                begin
                    state_next.e_ccnt = state_reg.e_ccnt + 3'h1;
                end
            end
            else
            begin
                state_next.e_ccnt = 3'h0;
            end

            // as critical output the flags follow each conversion
            if (alert_as_crit)
            begin
                clr_bits = 5'h1f;
                set_bits = cond_now;
            end
        end

        // a new event wins over a read-clear in the same cycle
        state_next.flags[6:2] = (state_reg.flags[6:2] & ~clr_bits) | set_bits;
        // outer critical bit tracks the pin state
        state_next.flags[TM_FLAG_ECRIT] = state_next.e_crit;
        // inner critical bit tracks the pin state
        state_next.flags[TM_FLAG_ICRIT] = state_next.i_crit;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= '0;
            state_reg.setup <= TM_RST_SETUP;
            state_reg.pace <= TM_RST_PACE;
            state_reg.iub <= TM_RST_UB;
            state_reg.ilb <= TM_RST_LB;
            state_reg.oub <= TM_RST_UB;
            state_reg.olb <= TM_RST_LB;
            state_reg.oub_frac <= TM_RST_FRAC;
            state_reg.olb_frac <= TM_RST_FRAC;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign conv_start = state_reg.conv_start;
    // range select passed to the converter
    assign range_ext = state_reg.setup[TM_SETUP_RANGE];
    // correction active while the disable bit is clear
    assign series_resistance_fix = ~state_reg.setup[TM_SETUP_FIX_OFF];
    assign adaptive_averaging_off = state_reg.setup[TM_SETUP_AVG_OFF];
    assign sample_pace_code = state_reg.pace;

    // open drain: only ever pulls low
    assign alert_pin_o = 1'b0;
    assign crit_pin_o = 1'b0;
    // mask applies only in interrupt mode and not as critical output
    assign alert_pin_oe = alert_as_crit ? (state_reg.i_crit | state_reg.e_crit)
                        : state_reg.setup[TM_SETUP_COMP] ? (state_reg.i_cmp | state_reg.e_cmp)
                        : (|state_reg.flags[6:2]) & ~state_reg.setup[TM_SETUP_MASK_ALL];
    assign crit_pin_oe = state_reg.i_crit | state_reg.e_crit;
endmodule

//--- bench/tm_monitor_chk_sva.sv
`timescale 1ns/100ps
module tm_monitor_chk
    import tm_pkg::*;
#(
    parameter logic [31:0] FAST_CYC = TM_FAST_CYC
)
(
    input logic clock,
    input logic srst,
    input logic [7:0] reg_addr,
    input logic reg_wr_en,
    input logic reg_rd_en,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid,
    input tm_sample_t sample,
    input tm_thresh_t thresh,
    input logic alert_as_crit,
    input logic conv_start,
    input logic range_ext,
    input logic series_resistance_fix,
    input logic adaptive_averaging_off,
    input logic [3:0] sample_pace_code,
    input logic alert_pin_o,
    input logic alert_pin_oe,
    input logic crit_pin_o,
    input logic crit_pin_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    logic wr_setup;
    logic wr_pace;
    assign wr_setup = reg_wr_en && (reg_addr == 8'h03 || reg_addr == 8'h09);
    assign wr_pace = reg_wr_en && (reg_addr == 8'h04 || reg_addr == 8'h0a);

    read_answer_a : assert property (reg_rd_en |=> reg_rvalid)
        else $error("read strobe not answered");
    read_pulse_a : assert property (!reg_rd_en |=> !reg_rvalid)
        else $error("read answer without strobe");
    rdata_hold_a : assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    pace_write_a : assert property (wr_pace |=> sample_pace_code == $past(reg_wdata[3:0]))
        else $error("pace code not taken from write");
    setup_write_a : assert property (wr_setup |=> range_ext == $past(reg_wdata[2])
        && series_resistance_fix == !$past(reg_wdata[4])
        && adaptive_averaging_off == $past(reg_wdata[1]))
        else $error("setup outputs not taken from write");
    setup_hold_a : assert property (!wr_setup |=>
        $stable({range_ext, series_resistance_fix, adaptive_averaging_off}))
        else $error("setup outputs moved without a write");
    crit_on_sample_a : assert property (!$stable(crit_pin_oe) |-> $past(sample.valid))
        else $error("critical pin moved without a result");
    inner_crit_a : assert property (sample.valid && thresh.crit_count <= 3'h1
        && sample.inner_temp > thresh.inner_crit_limit |=> crit_pin_oe)
        else $error("critical pin not driven on inner overtemperature");
    conv_pulse_a : assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    reset_values_a : assert property ($fell(srst) |-> sample_pace_code == 4'h6
        && series_resistance_fix && !range_ext && !alert_pin_oe && !crit_pin_oe)
        else $error("outputs wrong after reset");
    pin_level_a : assert property (!alert_pin_o && !crit_pin_o)
        else $error("open drain pin data not low");
endmodule

bind tm_monitor tm_monitor_chk #(.FAST_CYC(FAST_CYC)) chk (.*);

//--- bench/tm_conv_model.sv
`timescale 1ns/100ps
module tm_conv_model
    import tm_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic conv_start,
    input wire logic [3:0] lat,
    input wire tm_sample_t result,
    output tm_sample_t sample
);
    logic [3:0] cnt_reg;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_reg <= 4'h0;
            sample <= '0;
        end
        else
        begin
            // idle result lines toggle so a stale value is never mistaken for data
            sample <= {1'b0, ~sample[19:0]};
            if (conv_start)
                cnt_reg <= lat;
            else if (cnt_reg != 4'h0)
            begin
                cnt_reg <= cnt_reg - 4'h1;
                if (cnt_reg == 4'h1)
                    sample <= {1'b1, result[19:0]};
            end
        end
    end
endmodule

//--- bench/test_temp_monitor_status_config_limits.sv
`timescale 1ns/100ps
module test_temp_monitor_status_config_limits;
    import tm_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    tm_sample_t sample;
    tm_sample_t result = {1'b0, 8'h30, 8'h30, 3'h0, 1'b0};
    tm_thresh_t thresh = {8'h70, 8'h70, 8'h0a, 3'h1, 3'h1};
    logic conv_start;
    logic [3:0] lat = 4'h1;
    logic alert_as_crit = 1'b0;
    logic alert_pin_oe;
    logic crit_pin_oe;
    int num_errors = 0;
    int n_tests = 0;
    int n_conv = 0;
    int i;
    // register address, reset value
    localparam logic [15:0] RST_T [15] = '{16'h0300, 16'h0406, 16'h0555, 16'h0600,
        16'h0755, 16'h0800, 16'h0900, 16'h0a06, 16'h0b55, 16'h0c00, 16'h0d55, 16'h0e00,
        16'h1300, 16'h1400, 16'h3000};
    // setup, inner, outer, status, {frac[6:4], fault[3], alert[1], crit[0]}
    localparam logic [39:0] ROWS [12] = '{40'h4050550000, 40'h4051304002,
        40'h4010302002, 40'h4030551012, 40'h4030100802, 40'h403030040a,
        40'h4071304103, 40'h4030300000, 40'h4030711203, 40'h4030300000,
        40'hc051304000, 40'he051304002};

    tm_monitor #(.FAST_CYC(32'd16)) dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample(sample), .thresh(thresh),
        .alert_as_crit(alert_as_crit), .conv_start(conv_start), .range_ext(),
        .series_resistance_fix(), .adaptive_averaging_off(), .sample_pace_code(),
        .alert_pin_o(), .alert_pin_oe(alert_pin_oe), .crit_pin_o(),
        .crit_pin_oe(crit_pin_oe));
    tm_conv_model conv (.clock(clock), .srst(srst), .conv_start(conv_start), .lat(lat),
        .result(result), .sample(sample));

    initial
    begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (conv_start === 1'b1)
            n_conv++;
    end

    task automatic wrap_up;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clock);
        reg_rd_en = 1'b0;
        chk({7'h0, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask
    task automatic convert(input logic [3:0] l);
        int k;
        lat = l;
        wr(TM_ADDR_ONE_SHOT, 8'h00);
        for (k = 0; k < 40 && sample.valid !== 1'b1; k++)
            @(negedge clock);
        if (k == 40)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: no conversion result", $time);
            wrap_up();
        end
        repeat (2) @(negedge clock);
    endtask

    initial
    begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        for (i = 0; i < 15; i++)
            rdc(RST_T[i][15:8], RST_T[i][7:0]);
        wr(TM_ADDR_SETUP, 8'hff);
        rdc(TM_ADDR_SETUP_ALIAS, 8'hf6);
        wr(TM_ADDR_SETUP, 8'h40);
        wr(TM_ADDR_IUB_ALIAS, 8'h50);
        rdc(TM_ADDR_IUB, 8'h50);
        wr(TM_ADDR_PACE_ALIAS, 8'hfa);
        rdc(TM_ADDR_PACE, 8'h0a);
        wr(TM_ADDR_OLB_FRAC, 8'hff);
        rdc(TM_ADDR_OLB_FRAC, 8'he0);
        wr(TM_ADDR_ILB, 8'h10);
        wr(TM_ADDR_OLB, 8'h10);
        n_conv = 0;
        for (i = 0; i < 12; i++)
        begin
            wr(TM_ADDR_SETUP, ROWS[i][39:32]);
            result = {1'b0, ROWS[i][31:24], ROWS[i][23:16], ROWS[i][6:4], ROWS[i][3]};
            convert(i[0] ? 4'h9 : 4'h1);
            chk({7'h0, alert_pin_oe}, {7'h0, ROWS[i][1]});
            chk({7'h0, crit_pin_oe}, {7'h0, ROWS[i][0]});
            rdc(TM_ADDR_FLAGS, ROWS[i][15:8]);
        end
        chk(8'(n_conv), 8'd12);
        wr(TM_ADDR_SETUP, 8'h40);
        thresh.alert_count = 3'h2;
        result = {1'b0, 8'h51, 8'h30, 3'h0, 1'b0};
        convert(4'h1);
        rdc(TM_ADDR_FLAGS, 8'h00);
        convert(4'h1);
        rdc(TM_ADDR_FLAGS, 8'h40);
        thresh.alert_count = 3'h1;
        alert_as_crit = 1'b1;
        wr(TM_ADDR_SETUP, 8'hc0);
        result = {1'b0, 8'h71, 8'h30, 3'h0, 1'b0};
        convert(4'h1);
        chk({7'h0, alert_pin_oe}, 8'h01);
        rdc(TM_ADDR_FLAGS, 8'h41);
        rdc(TM_ADDR_FLAGS, 8'h41);
        result = {1'b0, 8'h51, 8'h30, 3'h0, 1'b0};
        convert(4'h1);
        chk({7'h0, alert_pin_oe}, 8'h00);
        rdc(TM_ADDR_FLAGS, 8'h40);
        alert_as_crit = 1'b0;
        // leaving standby converts at once, then on every pace tick
        wr(TM_ADDR_SETUP, 8'h00);
        repeat (100) @(negedge clock);
        wr(TM_ADDR_SETUP, 8'h40);
        chk({7'h0, n_conv >= 22}, 8'h01);
        repeat (4) @(negedge clock);
        i = n_conv;
        repeat (600) @(negedge clock);
        chk(8'(n_conv - i), 8'h00);
        wrap_up();
    end
endmodule
